// File: verilog/logic_gate_pkg.sv
// constants, types and helper functions of the logic gate array
// assumes a 20 MHz system clock and a 100 ms timebase tick
package logic_gate_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_GATES  = 16;
  localparam int unsigned NUM_INPUTS = 4;
  localparam int unsigned SEL_W      = 6;
  localparam int unsigned FACTOR_W   = 7;
  localparam int unsigned TICK_W     = 16;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned TICK_MS          = 100;
  localparam int unsigned TICK_CYCLES_DEF  = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned BASE_100MS_TICKS = 100 / TICK_MS;
  localparam int unsigned BASE_1S_TICKS    = 1000 / TICK_MS;
  localparam int unsigned BASE_1MIN_TICKS  = 60000 / TICK_MS;
  localparam int unsigned CYCLE_STEP_S     = 10;
  localparam int unsigned CYCLE_STEP_TICKS = CYCLE_STEP_S * 1000 / TICK_MS;
  localparam logic [15:0] TICKS_RESET      = 16'h0000;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_AND    = 2'b00,
    OP_OR     = 2'b01,
    OP_XOR    = 2'b10,
    OP_AND_FB = 2'b11
  } gate_op_t;

  typedef enum logic [1:0] {
    DLY_NONE      = 2'b00,
    DLY_IMMEDIATE = 2'b01,
    DLY_TIMED     = 2'b10
  } delay_mode_t;

  typedef enum logic [1:0] {
    BASE_100MS = 2'b00,
    BASE_1S    = 2'b01,
    BASE_1MIN  = 2'b10
  } delay_base_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // factor zero is taken as one so a delay never collapses to nothing
  function automatic logic [15:0] delay_ticks(input logic [1:0] base,
                                              input logic [6:0] factor);
    logic [15:0] f;
    logic [15:0] mul;
    f = {9'h000, (factor == 7'h00) ? 7'h01 : factor};
    case (delay_base_t'(base))
      BASE_1S:   mul = 16'(BASE_1S_TICKS);
      BASE_1MIN: mul = 16'(BASE_1MIN_TICKS);
      default:   mul = 16'(BASE_100MS_TICKS);
    endcase
    return 16'(f * mul);
  endfunction

  function automatic logic gate_eval(input gate_op_t op,
                                     input logic [1:0] cnt,
                                     input logic [3:0] eff);
    logic [3:0] act;
    act = 4'h0;
    for (int i = 0; i < 4; i++)
      act[i] = (2'(i) <= cnt);
    case (op)
      OP_OR:   return |(eff & act);
      OP_XOR:  return ^(eff & act);
      default: return &(eff | ~act);
    endcase
  endfunction

  // {found, index} of the lowest set bit
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--)
      if (v[i])
        r = {1'b1, 4'(i)};
    return r;
  endfunction

endpackage

// File: verilog/tick_prescaler.sv
// timebase prescaler: one-cycle tick every TICK_CYCLES clocks
// assumes a single free-running clock
`timescale 1ns/1ps
module tick_prescaler #(
  parameter int unsigned TICK_CYCLES = logic_gate_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // timebase
  output logic      tick
);

  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } pre_t;

  pre_t st_r;
  pre_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt >= 24'(TICK_CYCLES - 1))
    begin
      st_nxt.cnt = 24'h00_0000;
      st_nxt.tick = 1'b1;
    end
    else
      st_nxt.cnt = st_r.cnt + 24'h00_0001;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tick = st_r.tick;

  AST_TICK_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    (tick && TICK_CYCLES > 1) |=> !tick)
    else $error("timebase tick longer than one cycle");

endmodule

// File: verilog/tick_counter.sv
// retriggerable down counter in timebase ticks with expiry pulse
// assumes start and stop come from logic on the same clock
`timescale 1ns/1ps
module tick_counter (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // control
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [15:0] load,
  // status
  output logic             running,
  output logic             expired
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        run;
    logic        exp;
  } cnt_t;

  cnt_t st_r;
  cnt_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.exp = 1'b0;
    if (start)
    begin
      // restart from the full value on every trigger
      st_nxt.cnt = (load == 16'h0000) ? 16'h0001 : load;
      st_nxt.run = 1'b1;
    end
    else if (stop)
      st_nxt.run = 1'b0;
    else if (st_r.run && tick)
    begin
      if (st_r.cnt <= 16'h0001)
      begin
        st_nxt.run = 1'b0;
        st_nxt.exp = 1'b1;
      end
      else
        st_nxt.cnt = st_r.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign running = st_r.run;
  assign expired = st_r.exp;

  AST_RESTART_FULL: assert property (@(posedge clk) disable iff (!rstn)
    (start && load > 16'h0001) |=> (st_r.cnt == $past(load) && running && !expired))
    else $error("delay not restarted from full value");

endmodule

// File: verilog/logic_gate_array.sv
// sixteen configurable one-bit logic gates with delays and cyclic send
// assumes telegram ports and internal flags come from same-clock logic
//
// Notes on behaviour
// - sixteen gates, each enabled on its own
// - one to four inputs, unused ones ignored
// - operations AND, OR, XOR, AND with feedback
// - each input and output may be inverted
// - feedback mode needs input 1 set last
// - feedback: other input low clears output, input1
// - gate evaluates only on input events
// - gate loops allowed, harmless to others
// - each received one restarts switch-on delay
// - each received zero restarts switch-off delay
// - delayed output sent only after full expiry
// - per-gate send condition chooses emission
// - optional periodic resend at set interval
// - input from telegram or internal signal
// - selector picks internal output, error, limit
// - XOR is one for odd count
// - send every event or only on change
// - delay suppress, pass or timed base times factor
// - cyclic period in ten second steps, zero off
`timescale 1ns/1ps
module logic_gate_array #(
  parameter int unsigned TICK_CYCLES = logic_gate_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // gate configuration
  input  wire logic [15:0]  gateEnable,
  input  wire logic [31:0]  opSel,
  input  wire logic [31:0]  inCount,
  input  wire logic [15:0]  outInvert,
  input  wire logic [15:0]  sendOnChange,
  input  wire logic [31:0]  onMode,
  input  wire logic [31:0]  offMode,
  input  wire logic [31:0]  onBase,
  input  wire logic [31:0]  offBase,
  input  wire logic [111:0] onFactor,
  input  wire logic [111:0] offFactor,
  input  wire logic [111:0] cyclePeriod,
  // input configuration
  input  wire logic [63:0]  inInvert,
  input  wire logic [63:0]  srcInternal,
  input  wire logic [383:0] srcSel,
  // internal sources
  input  wire logic [31:0]  limitFlagSource,
  input  wire logic [15:0]  errorBit,
  // received telegrams
  input  wire logic         rxValid,
  input  wire logic [3:0]   rxGate,
  input  wire logic [1:0]   rxInput,
  input  wire logic         rxValue,
  // transmitted telegrams
  output logic              txValid,
  output logic [3:0]        txGate,
  output logic              txValue,
  // gate output states
  output logic [15:0]       gateOut
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0][3:0] inRaw;
    logic [15:0]      fbIn;
    logic [15:0]      logicRes;
    logic [15:0]      pendVal;
    logic [15:0]      outObj;
    logic [15:0]      sendReq;
    logic [63:0]      intPrev;
    logic             txValid;
    logic [3:0]       txGate;
    logic             txValue;
  } gate_state_t;

  gate_state_t st_r;
  gate_state_t st_nxt;

  logic              tick;
  logic [63:0]       intVec;
  logic [63:0]       intChg;
  logic [15:0][3:0]  rawAll;
  logic [15:0][3:0]  evAll;
  logic [15:0]       commitAll;
  logic [15:0]       sendSet;
  logic [15:0]       dlyStart;
  logic [15:0]       dlyStop;
  logic [15:0][15:0] dlyLoad;
  logic [15:0]       dlyRun;
  logic [15:0]       dlyExp;
  logic [15:0]       cycStart;
  logic [15:0]       cycStop;
  logic [15:0][15:0] cycLoad;
  logic [15:0]       cycRun;
  logic [15:0]       cycExp;

  // gate outputs are internal sources too, so gates may feed each other
  assign intVec = {st_r.outObj, errorBit, limitFlagSource};
  assign intChg = intVec ^ st_r.intPrev;

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  tick_prescaler #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_prescaler (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick)
  );

  for (genvar g = 0; g < 16; g++)
  begin : g_timer
    // zero period keeps the cyclic timer stopped
    assign cycStop[g]  = (cyclePeriod[g*7 +: 7] == 7'h00) || !gateEnable[g];
    assign cycStart[g] = !cycStop[g] && !cycRun[g];
    assign cycLoad[g]  = 16'({9'h000, cyclePeriod[g*7 +: 7]} *
                             16'(logic_gate_pkg::CYCLE_STEP_TICKS));
    tick_counter u_delay (
      .clk     (clk),
      .rstn    (rstn),
      .tick    (tick),
      .start   (dlyStart[g]),
      .stop    (dlyStop[g]),
      .load    (dlyLoad[g]),
      .running (dlyRun[g]),
      .expired (dlyExp[g])
    );
    tick_counter u_cyclic (
      .clk     (clk),
      .rstn    (rstn),
      .tick    (tick),
      .start   (cycStart[g]),
      .stop    (cycStop[g]),
      .load    (cycLoad[g]),
      .running (cycRun[g]),
      .expired (cycExp[g])
    );
  end

  // ----------------------------------------------------------------
  // gate evaluation
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [3:0]                  raw;
    logic [3:0]                  ev;
    logic [3:0]                  eff;
    logic [5:0]                  sel;
    logic                        res;
    logic                        commit;
    logic                        cval;
    logic                        obj;
    logic [4:0]                  grant;
    logic [15:0]                 pend;
    logic_gate_pkg::gate_op_t    op;
    logic_gate_pkg::delay_mode_t mode;
    raw = 4'h0;
    ev = 4'h0;
    eff = 4'h0;
    sel = 6'h00;
    res = 1'b0;
    commit = 1'b0;
    cval = 1'b0;
    obj = 1'b0;
    op = logic_gate_pkg::OP_AND;
    mode = logic_gate_pkg::DLY_NONE;
    grant = 5'h00;
    pend = 16'h0000;
    st_nxt = st_r;
    st_nxt.intPrev = intVec;
    rawAll = '0;
    evAll = '0;
    commitAll = 16'h0000;
    sendSet = 16'h0000;
    dlyStart = 16'h0000;
    dlyStop = 16'h0000;
    dlyLoad = '0;
    for (int g = 0; g < 16; g++)
    begin
      raw = st_r.inRaw[g];
      ev = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
        if (srcInternal[g*4+i])
        begin
          sel = srcSel[(g*4+i)*6 +: 6];
          if (intChg[sel])
          begin
            raw[i] = intVec[sel];
            ev[i] = 1'b1;
          end
        end
        else if (rxValid && rxGate == 4'(g) && rxInput == 2'(i))
        begin
          raw[i] = rxValue;
          ev[i] = 1'b1;
        end
      end
      if (!gateEnable[g])
        ev = 4'h0;
      rawAll[g] = raw;
      evAll[g] = ev;
      op = logic_gate_pkg::gate_op_t'(opSel[g*2 +: 2]);
      eff = raw ^ inInvert[g*4 +: 4];
      // input 1 follows the fed-back output unless an event, telegram or internal, just hit it
      if (op == logic_gate_pkg::OP_AND_FB && !ev[0])
        eff[0] = st_r.fbIn[g];
      res = logic_gate_pkg::gate_eval(op, inCount[g*2 +: 2], eff);
      commit = 1'b0;
      cval = res;
      if (op != logic_gate_pkg::OP_AND_FB)
        st_nxt.fbIn[g] = 1'b0;
      if (|ev)
      begin
        st_nxt.inRaw[g] = raw;
        st_nxt.logicRes[g] = res;
        if (op == logic_gate_pkg::OP_AND_FB)
          st_nxt.fbIn[g] = res;
        mode = logic_gate_pkg::delay_mode_t'(res ? onMode[g*2 +: 2] : offMode[g*2 +: 2]);
        case (mode)
          logic_gate_pkg::DLY_NONE:
          begin
            // transition is taken over silently, nothing goes out
            dlyStop[g] = 1'b1;
            st_nxt.outObj[g] = res ^ outInvert[g];
          end
          logic_gate_pkg::DLY_TIMED:
          begin
            dlyStart[g] = 1'b1;
            dlyLoad[g] = res ?
              logic_gate_pkg::delay_ticks(onBase[g*2 +: 2], onFactor[g*7 +: 7]) :
              logic_gate_pkg::delay_ticks(offBase[g*2 +: 2], offFactor[g*7 +: 7]);
            st_nxt.pendVal[g] = res;
          end
          default:
          begin
            dlyStop[g] = 1'b1;
            commit = 1'b1;
          end
        endcase
      end
      else if (dlyExp[g])
      begin
        commit = 1'b1;
        cval = st_r.pendVal[g];
      end
      if (!gateEnable[g])
        dlyStop[g] = 1'b1;
      commitAll[g] = commit;
      obj = cval ^ outInvert[g];
      if (commit)
      begin
        if (!sendOnChange[g] || obj != st_r.outObj[g])
          sendSet[g] = 1'b1;
        st_nxt.outObj[g] = obj;
      end
      if (cycExp[g] && gateEnable[g])
        sendSet[g] = 1'b1;
    end
    // one telegram per cycle, lowest gate first; a new request beats the clear
    pend = st_r.sendReq & gateEnable;
    grant = logic_gate_pkg::first_set(pend);
    st_nxt.txValid = grant[4];
    st_nxt.txGate = grant[3:0];
    st_nxt.txValue = st_r.outObj[grant[3:0]];
    if (grant[4])
      pend[grant[3:0]] = 1'b0;
    st_nxt.sendReq = pend | sendSet;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign txValid = st_r.txValid;
  assign txGate  = st_r.txGate;
  assign txValue = st_r.txValue;
  assign gateOut = st_r.outObj;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_DISABLED_SILENT: assert property (@(posedge clk) disable iff (!rstn)
    (!gateEnable[9] [*2]) |-> !(txValid && txGate == 4'h9))
    else $error("disabled gate transmitted");
  AST_SINGLE_INPUT: assert property (@(posedge clk) disable iff (!rstn)
    (|evAll[0] && opSel[1:0] == 2'b01 && inCount[1:0] == 2'b00)
    |=> st_r.logicRes[0] == ($past(rawAll[0][0]) ^ $past(inInvert[0])))
    else $error("unused input took part in evaluation");
  AST_XOR_ODD: assert property (@(posedge clk) disable iff (!rstn)
    (|evAll[2] && opSel[5:4] == 2'h2 && inCount[5:4] == 2'h2)
    |=> st_r.logicRes[2] == ^($past(rawAll[2][2:0]) ^ $past(inInvert[10:8])))
    else $error("xor result not odd parity");
  AST_OUT_INVERT: assert property (@(posedge clk) disable iff (!rstn)
    (|evAll[2] && onMode[5:4] == 2'h1 && offMode[5:4] == 2'h1)
    |=> gateOut[2] == (st_r.logicRes[2] ^ $past(outInvert[2])))
    else $error("output polarity wrong");
  AST_FB_CLEARED: assert property (@(posedge clk) disable iff (!rstn)
    (opSel[7:6] == 2'h3 && inCount[7:6] != 2'h0 && evAll[3][1] &&
     !(rawAll[3][1] ^ inInvert[13]))
    |=> (!st_r.fbIn[3] && !st_r.logicRes[3]))
    else $error("feedback input held while output low");
  AST_FB_ORDER: assert property (@(posedge clk) disable iff (!rstn)
    (opSel[7:6] == 2'h3 && |evAll[3] && !evAll[3][0] && !st_r.fbIn[3])
    |=> !st_r.logicRes[3])
    else $error("feedback gate set without input 1");
  AST_EVENT_ONLY: assert property (@(posedge clk) disable iff (!rstn)
    !(|evAll[0]) |=> $stable(st_r.logicRes[0]))
    else $error("gate evaluated without an event");
  AST_HOLD_DELAY: assert property (@(posedge clk) disable iff (!rstn)
    (dlyRun[5] && !dlyExp[5] && !(|evAll[5])) |=> $stable(gateOut[5]))
    else $error("output moved while delay running");
  AST_CHANGE_ONLY: assert property (@(posedge clk) disable iff (!rstn)
    (commitAll[1] && sendOnChange[1] && !cycExp[1] &&
     (st_nxt.outObj[1] == st_r.outObj[1]) && !st_r.sendReq[1])
    |=> !st_r.sendReq[1])
    else $error("unchanged output sent in change mode");
  AST_CYCLIC_SEND: assert property (@(posedge clk) disable iff (!rstn)
    (cycExp[7] && gateEnable[7]) |=> st_r.sendReq[7])
    else $error("cyclic expiry not sent");
  AST_CYCLIC_OFF: assert property (@(posedge clk) disable iff (!rstn)
    (cyclePeriod[6:0] == 7'h00) [*3] |-> !cycExp[0])
    else $error("cyclic send with zero period");
  AST_EXT_INPUT: assert property (@(posedge clk) disable iff (!rstn)
    (gateEnable[0] && !srcInternal[0] && rxValid && rxGate == 4'h0 && rxInput == 2'b00)
    |=> st_r.inRaw[0][0] == $past(rxValue))
    else $error("telegram not taken by external input");

endmodule

// File: sim/bus_peer.sv
// other bus participants: sends one-bit telegrams, tallies the gates' telegrams
// assumes the same clock as the gate array and a bench that calls send
`timescale 1ns/1ps
module bus_peer (
  // clock
  input  wire logic       clk,
  // telegrams towards the gates
  output logic            rxValid,
  output logic [3:0]      rxGate,
  output logic [1:0]      rxInput,
  output logic            rxValue,
  // telegrams from the gates
  input  wire logic       txValid,
  input  wire logic [3:0] txGate,
  input  wire logic       txValue
);
  int   nTx [16];
  logic lastVal [16];

  initial
  begin
    rxValid = 1'b0;
    rxGate  = 4'h0;
    rxInput = 2'h0;
    rxValue = 1'b0;
    foreach (nTx[k])
      nTx[k] = 0;
  end

  // ----------------------------------------------------------------
  // one telegram, held for exactly one sampled edge
  // ----------------------------------------------------------------
  task automatic send(input logic [3:0] g, input logic [1:0] i, input logic v);
    @(posedge clk);
    #1;
    rxValid = 1'b1;
    rxGate  = g;
    rxInput = i;
    rxValue = v;
    @(posedge clk);
    #1;
    // released lines show garbage, never the last value
    rxValid = 1'b0;
    rxGate  = ~g;
    rxInput = ~i;
    rxValue = ~v;
  endtask

  // ----------------------------------------------------------------
  // receive side
  // ----------------------------------------------------------------
  always @(posedge clk)
    if (txValid === 1'b1)
    begin
      nTx[txGate] = nTx[txGate] + 1;
      lastVal[txGate] = txValue;
    end
endmodule

// File: sim/logic_gate_array_bench.sv
// self-checking bench of the logic gate array, telegrams via bus_peer
// assumes a 10-cycle timebase tick so delays and cycles stay short
`timescale 1ns/1ps
module logic_gate_array_bench;
  logic         clk;
  logic         rstn;
  logic [15:0]  gateEnable;
  logic [31:0]  opSel;
  logic [31:0]  inCount;
  logic [15:0]  outInvert;
  logic [15:0]  sendOnChange;
  logic [31:0]  onMode;
  logic [31:0]  offMode;
  logic [31:0]  onBase;
  logic [31:0]  offBase;
  logic [111:0] onFactor;
  logic [111:0] cyclePeriod;
  logic [63:0]  inInvert;
  logic [63:0]  srcInternal;
  logic [383:0] srcSel;
  logic [31:0]  limitFlagSource;
  logic [15:0]  errorBit;
  logic         rxValid;
  logic [3:0]   rxGate;
  logic [1:0]   rxInput;
  logic         rxValue;
  logic         txValid;
  logic [3:0]   txGate;
  logic         txValue;
  logic [15:0]  gateOut;
  int           fails;
  int           nTests;
  int           n0;

  always #25 clk = ~clk;

  logic_gate_array #(.TICK_CYCLES(10)) DUT (
    .clk(clk), .rstn(rstn), .gateEnable(gateEnable), .opSel(opSel), .inCount(inCount),
    .outInvert(outInvert), .sendOnChange(sendOnChange), .onMode(onMode),
    .offMode(offMode), .onBase(onBase), .offBase(offBase), .onFactor(onFactor),
    .offFactor(onFactor), .cyclePeriod(cyclePeriod), .inInvert(inInvert),
    .srcInternal(srcInternal), .srcSel(srcSel), .limitFlagSource(limitFlagSource),
    .errorBit(errorBit), .rxValid(rxValid), .rxGate(rxGate), .rxInput(rxInput),
    .rxValue(rxValue), .txValid(txValid), .txGate(txGate), .txValue(txValue),
    .gateOut(gateOut));

  bus_peer peer (
    .clk(clk), .rxValid(rxValid), .rxGate(rxGate), .rxInput(rxInput),
    .rxValue(rxValue), .txValid(txValid), .txGate(txGate), .txValue(txValue));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic completeRun;
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    nTests++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // output level, telegram count, and the last telegram carries the output
  task automatic expect_gate(input string what, input int g, input logic o, input int n);
    check({what, " out"}, {15'h0000, o}, {15'h0000, gateOut[g]});
    check({what, " count"}, 16'(n), 16'(peer.nTx[g]));
    if (n > 0)
      check({what, " value"}, {15'h0000, o}, {15'h0000, peer.lastVal[g]});
  endtask

  task automatic put(input int g, input int i, input logic v);
    peer.send(4'(g), 2'(i), v);
    cyc(5);
  endtask

  task automatic set_gate(input int g, input logic [1:0] op, input logic [1:0] cnt,
                          input logic chg, input logic [1:0] onM, input logic [1:0] offM,
                          input logic [6:0] f, input logic [6:0] cycle);
    gateEnable[g]         = 1'b1;
    opSel[g*2+:2]         = op;
    inCount[g*2+:2]       = cnt;
    sendOnChange[g]       = chg;
    onMode[g*2+:2]        = onM;
    offMode[g*2+:2]       = offM;
    onFactor[g*7+:7]      = f;
    cyclePeriod[g*7+:7]   = cycle;
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    #(50 * 10000);
    fails++;
    completeRun();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    {gateEnable, opSel, inCount, outInvert, sendOnChange} = '0;
    {onMode, offMode, onBase, offBase, onFactor, cyclePeriod} = '0;
    {inInvert, srcInternal, srcSel, limitFlagSource, errorBit} = '0;
    set_gate(0, 2'h1, 2'h0, 1'b0, 2'h1, 2'h1, 7'h01, 7'h00);
    set_gate(1, 2'h0, 2'h1, 1'b1, 2'h1, 2'h1, 7'h01, 7'h00);
    set_gate(2, 2'h2, 2'h2, 1'b0, 2'h1, 2'h1, 7'h01, 7'h00);
    set_gate(3, 2'h3, 2'h1, 1'b0, 2'h1, 2'h1, 7'h01, 7'h00);
    set_gate(4, 2'h1, 2'h1, 1'b0, 2'h1, 2'h1, 7'h01, 7'h00);
    set_gate(5, 2'h1, 2'h0, 1'b0, 2'h2, 2'h2, 7'h04, 7'h00);
    set_gate(6, 2'h1, 2'h0, 1'b0, 2'h0, 2'h1, 7'h01, 7'h00);
    set_gate(7, 2'h1, 2'h0, 1'b0, 2'h1, 2'h1, 7'h01, 7'h01); // no delay below period
    set_gate(8, 2'h1, 2'h0, 1'b0, 2'h1, 2'h1, 7'h01, 7'h00);
    set_gate(9, 2'h1, 2'h0, 1'b0, 2'h1, 2'h1, 7'h01, 7'h00);
    set_gate(10, 2'h1, 2'h0, 1'b0, 2'h2, 2'h3, 7'h01, 7'h00);
    onBase[20+:2] = 2'h1;
    gateEnable[9] = 1'b0;
    outInvert[2] = 1'b1;
    inInvert[10] = 1'b1;
    srcInternal[16] = 1'b1;
    srcInternal[17] = 1'b1;
    srcInternal[32] = 1'b1;
    srcSel[96+:6] = 6'h05;
    srcSel[102+:6] = 6'h23;
    srcSel[192+:6] = 6'h30;
    cyc(20);
    rstn = 1'b1;
    cyc(3);
    check("outputs after reset", 16'h0000, gateOut);
    put(0, 0, 1'b1);
    expect_gate("or on", 0, 1'b1, 1);
    check("chained gate", 16'h0001, {15'h0000, gateOut[8]});
    put(0, 0, 1'b1);
    expect_gate("or repeat", 0, 1'b1, 2);
    put(0, 0, 1'b0);
    expect_gate("or off", 0, 1'b0, 3);
    check("chained gate off", 16'h0000, {15'h0000, gateOut[8]});
    put(1, 0, 1'b1);
    expect_gate("and half", 1, 1'b0, 0);
    put(1, 1, 1'b1);
    expect_gate("and full", 1, 1'b1, 1);
    put(1, 2, 1'b0);
    expect_gate("and unused", 1, 1'b1, 1);
    put(2, 0, 1'b1);
    expect_gate("xor even", 2, 1'b1, 1);
    put(2, 1, 1'b1);
    expect_gate("xor odd", 2, 1'b0, 2);
    put(2, 2, 1'b1);
    expect_gate("xor inverted in", 2, 1'b1, 3);
    put(3, 0, 1'b1);
    put(3, 1, 1'b1);
    expect_gate("fb early in1", 3, 1'b0, 2);
    put(3, 0, 1'b1);
    expect_gate("fb in1 last", 3, 1'b1, 3);
    put(3, 1, 1'b0);
    expect_gate("fb drop", 3, 1'b0, 4);
    put(3, 1, 1'b1);
    expect_gate("fb in1 cleared", 3, 1'b0, 5);
    limitFlagSource[5] = 1'b1;
    cyc(5);
    expect_gate("limit source", 4, 1'b1, 1);
    put(4, 0, 1'b0);
    expect_gate("rx to internal", 4, 1'b1, 1);
    limitFlagSource[5] = 1'b0;
    errorBit[3] = 1'b1;
    cyc(5);
    expect_gate("error source", 4, 1'b1, 2);
    errorBit[3] = 1'b0;
    cyc(5);
    expect_gate("error source off", 4, 1'b0, 3);
    // each pass: restart the delay once, then let it run out
    for (int p = 0; p < 2; p++)
    begin
      put(5, 0, p == 0);
      cyc(20);
      expect_gate("delay early", 5, p != 0, p);
      put(5, 0, p == 0);
      cyc(20);
      expect_gate("delay retrigger", 5, p != 0, p);
      cyc(25);
      expect_gate("delay expired", 5, p == 0, p + 1);
    end
    put(6, 0, 1'b1);
    expect_gate("suppressed", 6, 1'b1, 0);
    put(9, 0, 1'b1);
    expect_gate("disabled", 9, 1'b0, 0);
    // one second base: ten ticks, so nothing may show before ninety cycles
    put(10, 0, 1'b1);
    cyc(80);
    expect_gate("base 1s early", 10, 1'b0, 0);
    cyc(40);
    expect_gate("base 1s expired", 10, 1'b1, 1);
    put(10, 0, 1'b0);
    expect_gate("mode 3 no delay", 10, 1'b0, 2);
    put(7, 0, 1'b1);
    n0 = peer.nTx[7];
    for (int k = 0; k < 1100 && peer.nTx[7] == n0; k++)
      cyc(1);
    check("cyclic first", 16'(n0 + 1), 16'(peer.nTx[7]));
    cyc(990);
    check("cyclic gap", 16'(n0 + 1), 16'(peer.nTx[7]));
    cyc(30);
    expect_gate("cyclic again", 7, 1'b1, n0 + 2);
    rstn = 1'b0;
    cyc(1);
    check("outputs in reset", 16'h0000, gateOut);
    completeRun();
  end
endmodule
